/* File: shared/pbsram_pkg.sv */
// shared constants, state encoding and burst address helper for the pipelined burst sram
package pbsram_pkg;

  // array geometry
  localparam int ADDR_W     = 16;
  localparam int DATA_W     = 18;
  localparam int WORDS      = 65536;
  localparam int LANES      = 2;
  localparam int CNT_W      = 2;

  // byte lane field positions on the data word
  localparam int LANE_LO_LSB = 0;
  localparam int LANE_LO_MSB = 8;
  localparam int LANE_HI_LSB = 9;
  localparam int LANE_HI_MSB = 17;
  localparam int LANE_LO     = 0;
  localparam int LANE_HI     = 1;

  // counter and lane constants
  localparam logic [CNT_W-1:0] CNT_ZERO   = 2'h0;
  localparam logic [CNT_W-1:0] CNT_ONE    = 2'h1;
  localparam logic [LANES-1:0] LANES_NONE = 2'h0;

  // burst tracking states, gray along deselect -> first -> continue
  typedef enum logic [1:0] {
    PBSRAM_DESEL = 2'h0,
    PBSRAM_FIRST = 2'h1,
    PBSRAM_BURST = 2'h3
  } pbsram_state_t;

  // complete control state of the top module
  typedef struct packed {
    pbsram_state_t            st;
    logic [ADDR_W-1:0]        base;
    logic [CNT_W-1:0]         cnt;
    logic [DATA_W-1:0]        wdata;
    logic [LANES-1:0]         lane_wr;
    logic                     rd;
  } pbsram_ctl_t;

  localparam pbsram_ctl_t CTL_RST = '{st: PBSRAM_DESEL, base: 16'h0000, cnt: 2'h0,
                                       wdata: 18'h00000, lane_wr: 2'h0, rd: 1'b0};

  // access address: upper bits held, low bits of the base flipped by the counter
  function automatic logic [ADDR_W-1:0] burst_addr(input logic [ADDR_W-1:0] base,
                                                   input logic [CNT_W-1:0]  cnt);
    burst_addr = {base[ADDR_W-1:CNT_W], base[CNT_W-1:0] ^ cnt};
  endfunction : burst_addr

endpackage : pbsram_pkg

/* File: rtl/pbsram_array.sv */
// storage array with byte lane writes and a registered read port
`timescale 1ns/1ps
module pbsram_array
  import pbsram_pkg::*;
(
  // clock, reset, enable
  input  wire logic                            clk_i,
  input  wire logic                            reset_n_i,
  input  wire logic                            ce_i,
  // access request from the control stage
  input  wire logic [pbsram_pkg::ADDR_W-1:0]   addr_i,
  input  wire logic [pbsram_pkg::DATA_W-1:0]   wdata_i,
  input  wire logic [pbsram_pkg::LANES-1:0]    lane_wr_i,
  input  wire logic                            rd_i,
  // registered read result
  output logic      [pbsram_pkg::DATA_W-1:0]   rdata_o,
  output logic                                 rd_valid_o
);

  typedef struct packed {
    logic [DATA_W-1:0] rdata;
    logic              rd_valid;
  } pbsram_arr_t;

  pbsram_arr_t                cur_ff;
  pbsram_arr_t                nxt_arr;
  logic [DATA_W-1:0]          mem [WORDS];

  // output register: read data of the previous cycle's access
  always_comb
  begin
    nxt_arr          = cur_ff;
    nxt_arr.rd_valid = rd_i;
    if (rd_i)
    begin
      nxt_arr.rdata = mem[addr_i];
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      cur_ff <= '{rdata: 18'h00000, rd_valid: 1'b0};
    else if (ce_i)
      cur_ff <= nxt_arr;
  end

  // self-timed write on the clock edge, one lane per enable
  always_ff @(posedge clk_i)
  begin
    if (ce_i && lane_wr_i[LANE_LO])
      mem[addr_i][LANE_LO_MSB:LANE_LO_LSB] <= wdata_i[LANE_LO_MSB:LANE_LO_LSB];
    if (ce_i && lane_wr_i[LANE_HI])
      mem[addr_i][LANE_HI_MSB:LANE_HI_LSB] <= wdata_i[LANE_HI_MSB:LANE_HI_LSB];
  end

  assign rdata_o    = cur_ff.rdata;
  assign rd_valid_o = cur_ff.rd_valid;

  // lower lane write lands in the word one edge later
  lane_lo_write_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    ce_i && lane_wr_i[LANE_LO] |=> mem[$past(addr_i)][LANE_LO_MSB:LANE_LO_LSB]
                                   == $past(wdata_i[LANE_LO_MSB:LANE_LO_LSB]))
    else $error("lower lane write not stored");

endmodule : pbsram_array

/* File: rtl/pbsram_top.sv */
// pipelined burst static memory: input registers, burst counter, array and gated data pins
`timescale 1ns/1ps
module pbsram_top
  import pbsram_pkg::*;
(
  // clock, reset, enable
  input  wire logic                            clk_i,
  input  wire logic                            reset_n_i,
  input  wire logic                            ce_i,
  // address and burst controls
  input  wire logic [pbsram_pkg::ADDR_W-1:0]   word_addr_in_i,
  input  wire logic                            proc_addr_strobe_n_i,
  input  wire logic                            ctrl_addr_strobe_n_i,
  input  wire logic                            burst_step_n_i,
  input  wire logic                            chip_sel_n_i,
  // byte write enables
  input  wire logic                            low_byte_wr_n_i,
  input  wire logic                            high_byte_wr_n_i,
  // asynchronous output enable
  input  wire logic                            out_en_n_i,
  // shared data pins, split into in, out and enable
  input  wire logic [pbsram_pkg::DATA_W-1:0]   shared_data_pins_i,
  output logic      [pbsram_pkg::DATA_W-1:0]   shared_data_pins_o,
  output logic                                 shared_data_pins_oe_n_o
);

  pbsram_ctl_t                cur_ff;
  pbsram_ctl_t                nxt_ctl;
  logic [LANES-1:0]           lanes_req;
  logic                       wr_any;
  logic                       load_req;
  logic [ADDR_W-1:0]          acc_addr;
  logic [DATA_W-1:0]          rdata;
  logic                       rd_valid;

  // byte enables as active-high lanes
  assign lanes_req = {~high_byte_wr_n_i, ~low_byte_wr_n_i};
  assign wr_any    = |lanes_req;
  assign load_req  = ~proc_addr_strobe_n_i | ~ctrl_addr_strobe_n_i;

  // next control state: load, continue, suspend or deselect
  always_comb
  begin
    nxt_ctl         = cur_ff;
    nxt_ctl.wdata   = shared_data_pins_i;
    nxt_ctl.lane_wr = LANES_NONE;
    nxt_ctl.rd      = 1'b0;
    if (!proc_addr_strobe_n_i)
    begin
      // processor start: read only, enables and other strobe ignored
      if (chip_sel_n_i)
      begin
        nxt_ctl.st = PBSRAM_DESEL;
      end
      else
      begin
        nxt_ctl.st   = PBSRAM_FIRST;
        nxt_ctl.base = word_addr_in_i;
        nxt_ctl.cnt  = CNT_ZERO;
        nxt_ctl.rd   = 1'b1;
      end
    end
    else if (!ctrl_addr_strobe_n_i)
    begin
      // controller start: write when any lane enabled, else read
      if (chip_sel_n_i)
      begin
        nxt_ctl.st = PBSRAM_DESEL;
      end
      else
      begin
        nxt_ctl.st   = PBSRAM_FIRST;
        nxt_ctl.base = word_addr_in_i;
        nxt_ctl.cnt  = CNT_ZERO;
        if (wr_any)
          nxt_ctl.lane_wr = lanes_req;
        else
          nxt_ctl.rd = 1'b1;
      end
    end
    else
    begin
      // both strobes high: chip select ignored here
      unique case (cur_ff.st)
        PBSRAM_DESEL:
        begin
          nxt_ctl.st = PBSRAM_DESEL;
        end
        PBSRAM_FIRST, PBSRAM_BURST:
        begin
          nxt_ctl.st = PBSRAM_BURST;
          if (!burst_step_n_i)
            nxt_ctl.cnt = cur_ff.cnt + CNT_ONE;
          if (wr_any)
            nxt_ctl.lane_wr = lanes_req;
          else
            nxt_ctl.rd = 1'b1;
        end
        default:
        begin
          nxt_ctl.st = PBSRAM_DESEL;
        end
      endcase
    end
  end

  // control register, frozen while the enable is low
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      cur_ff <= CTL_RST;
    else if (ce_i)
      cur_ff <= nxt_ctl;
  end

  // access address from base and counter
  assign acc_addr = burst_addr(cur_ff.base, cur_ff.cnt);

  // storage array and output register
  pbsram_array u_array (
    .clk_i      (clk_i),
    .reset_n_i  (reset_n_i),
    .ce_i       (ce_i),
    .addr_i     (acc_addr),
    .wdata_i    (cur_ff.wdata),
    .lane_wr_i  (cur_ff.lane_wr),
    .rd_i       (cur_ff.rd),
    .rdata_o    (rdata),
    .rd_valid_o (rd_valid)
  );

  // pins carry the output register; enable gated without the clock
  assign shared_data_pins_o      = rdata;
  assign shared_data_pins_oe_n_o = out_en_n_i | ~rd_valid;

  // checks of the burst and pin behaviour
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);

  sequence proc_start_s;
    ce_i && !proc_addr_strobe_n_i && !chip_sel_n_i;
  endsequence

  sequence ctrl_start_s;
    ce_i && proc_addr_strobe_n_i && !ctrl_addr_strobe_n_i && !chip_sel_n_i;
  endsequence

  sequence cont_step_s;
    ce_i && proc_addr_strobe_n_i && ctrl_addr_strobe_n_i && !burst_step_n_i;
  endsequence

  sequence cont_hold_s;
    ce_i && proc_addr_strobe_n_i && ctrl_addr_strobe_n_i && burst_step_n_i;
  endsequence

  sequence burst_load_s;
    proc_start_s or ctrl_start_s;
  endsequence

  // processor start loads the address and reads, never writes
  proc_read_load_a: assert property (
    proc_start_s |=> cur_ff.rd && cur_ff.lane_wr == LANES_NONE
                     && cur_ff.base == $past(word_addr_in_i) && cur_ff.cnt == CNT_ZERO)
    else $error("processor strobe did not load a read");

  // controller start writes exactly the enabled lanes
  ctrl_write_lanes_a: assert property (
    ctrl_start_s and (ce_i && wr_any) |=> !cur_ff.rd && cur_ff.lane_wr == $past(lanes_req))
    else $error("controller strobe write lanes wrong");

  // controller start with no lane enabled reads
  ctrl_read_a: assert property (
    ctrl_start_s and (ce_i && !wr_any) |=> cur_ff.rd && cur_ff.lane_wr == LANES_NONE)
    else $error("controller strobe read missing");

  // strobe with chip select high deselects and stays quiet
  strobe_deselect_a: assert property (
    ce_i && load_req && chip_sel_n_i |=> cur_ff.st == PBSRAM_DESEL && !cur_ff.rd
                                         && cur_ff.lane_wr == LANES_NONE)
    else $error("deselect on strobe not taken");

  // deselected continuation neither writes nor moves the counter
  desel_quiet_a: assert property (
    ce_i && cur_ff.st == PBSRAM_DESEL && !load_req
      |=> cur_ff.st == PBSRAM_DESEL && cur_ff.lane_wr == LANES_NONE && $stable(cur_ff.cnt))
    else $error("deselected cycle changed state");

  // advance low steps the counter by one with wrap
  step_count_a: assert property (
    cont_step_s and (ce_i && cur_ff.st != PBSRAM_DESEL)
      |=> cur_ff.cnt == $past(cur_ff.cnt) + CNT_ONE && $stable(cur_ff.base))
    else $error("burst step not taken");

  // advance high holds the address and repeats the access
  hold_addr_a: assert property (
    cont_hold_s and (ce_i && cur_ff.st != PBSRAM_DESEL)
      |=> $stable(acc_addr) && (cur_ff.rd || cur_ff.lane_wr != LANES_NONE))
    else $error("suspended burst moved address");

  // three steps after a load both low bits are inverted, upper fixed
  third_addr_a: assert property (
    (proc_start_s or ctrl_start_s) ##1 cont_step_s [*3]
      |=> acc_addr[ADDR_W-1:CNT_W] == cur_ff.base[ADDR_W-1:CNT_W]
          && acc_addr[CNT_W-1:0] == ~cur_ff.base[CNT_W-1:0])
    else $error("burst order wrong");

  // four steps after a load the address is the base again
  wrap_base_a: assert property (
    (proc_start_s or ctrl_start_s) ##1 cont_step_s [*4] |=> acc_addr == cur_ff.base)
    else $error("burst did not wrap");

  // read issued is on the pins two enabled edges after the request
  read_pipe_a: assert property (
    proc_start_s ##1 ce_i |=> rd_valid && (out_en_n_i || !shared_data_pins_oe_n_o))
    else $error("pipelined read data missing");

  // pins float whenever the output register holds no read
  pin_float_a: assert property (
    !rd_valid || out_en_n_i |-> shared_data_pins_oe_n_o)
    else $error("pins driven outside enabled read");

  // controller start loads the base and clears the counter
  ctrl_load_addr_a: assert property (
    ctrl_start_s
      |=> cur_ff.st == PBSRAM_FIRST && cur_ff.base == $past(word_addr_in_i) && cur_ff.cnt == CNT_ZERO)
    else $error("controller strobe did not load the base");

  // processor strobe wins over controller strobe and write enables
  proc_over_ctrl_a: assert property (
    proc_start_s and (ce_i && !ctrl_addr_strobe_n_i && wr_any)
      |=> cur_ff.rd && cur_ff.lane_wr == LANES_NONE)
    else $error("processor strobe lost to controller strobe");

  // burst continuation ignores chip select
  cont_select_a: assert property (
    ce_i && cur_ff.st != PBSRAM_DESEL && !load_req
      |=> cur_ff.st == PBSRAM_BURST)
    else $error("burst continuation dropped");

  // write data registered from the pins on every enabled edge
  data_capture_a: assert property (
    ce_i
      |=> cur_ff.wdata == $past(shared_data_pins_i))
    else $error("write data not registered");

  // pin driver enable tracks the output enable while a read is held
  oe_follow_a: assert property (
    rd_valid
      |-> shared_data_pins_oe_n_o == out_en_n_i)
    else $error("output enable not passed to the pins");

  // advance low always performs an access at the stepped address
  step_access_a: assert property (
    cont_step_s and (ce_i && cur_ff.st != PBSRAM_DESEL)
      |=> cur_ff.rd || cur_ff.lane_wr != LANES_NONE)
    else $error("stepped burst cycle made no access");

  // suspended write repeats the enabled lanes at the same address
  hold_write_a: assert property (
    cont_hold_s and (ce_i && cur_ff.st != PBSRAM_DESEL && wr_any)
      |=> !cur_ff.rd && cur_ff.lane_wr == $past(lanes_req))
    else $error("suspended write lanes wrong");

  // first step after a load flips only the lowest address bit
  first_addr_a: assert property (
    burst_load_s ##1 cont_step_s
      |=> acc_addr[ADDR_W-1:CNT_W] == cur_ff.base[ADDR_W-1:CNT_W]
          && (acc_addr[CNT_W-1:0] ^ cur_ff.base[CNT_W-1:0]) == CNT_ONE)
    else $error("first burst address wrong");

  // second step after a load flips only the next address bit
  second_addr_a: assert property (
    burst_load_s ##1 cont_step_s [*2]
      |=> acc_addr[ADDR_W-1:CNT_W] == cur_ff.base[ADDR_W-1:CNT_W]
          && (acc_addr[CNT_W-1:0] ^ cur_ff.base[CNT_W-1:0]) == CNT_ONE + CNT_ONE)
    else $error("second burst address wrong");

  // deselected continuation issues no read
  desel_no_read_a: assert property (
    ce_i && cur_ff.st == PBSRAM_DESEL && !load_req
      |=> !cur_ff.rd)
    else $error("deselected cycle read the array");

endmodule : pbsram_top

/* File: verif/pbsram_host.sv */
// host model: processor and cache controller on the memory bus
`timescale 1ns/1ps
module pbsram_host
  import pbsram_pkg::*;
(
  // clock
  input  wire logic                        clk_i,
  // select, strobes and advance
  output logic                             chip_sel_n_o,
  output logic                             proc_addr_strobe_n_o,
  output logic                             ctrl_addr_strobe_n_o,
  output logic                             burst_step_n_o,
  // byte write enables and output enable
  output logic                             low_byte_wr_n_o,
  output logic                             high_byte_wr_n_o,
  output logic                             out_en_n_o,
  // address and write data
  output logic [pbsram_pkg::ADDR_W-1:0]    word_addr_in_o,
  output logic [pbsram_pkg::DATA_W-1:0]    data_o
);
  logic oe_req;
  // idle bus at time zero
  initial
  begin
    {chip_sel_n_o, proc_addr_strobe_n_o, ctrl_addr_strobe_n_o, burst_step_n_o} = 4'hF;
    {low_byte_wr_n_o, high_byte_wr_n_o, out_en_n_o} = 3'h7;
    word_addr_in_o = 16'h0000;
    data_o = 18'h00000;
    oe_req = 1'b0;
  end
  // one bus cycle: drive after the edge, hold through the next edge
  task automatic cyc(input logic [5:0] ctl, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    logic load;
    logic wr;
    load = !(ctl[4] && ctl[3]);
    wr = ctl[4] && !(ctl[1] && ctl[0]);
    chip_sel_n_o = load ? ctl[5] : ~chip_sel_n_o;
    {proc_addr_strobe_n_o, ctrl_addr_strobe_n_o, burst_step_n_o} = ctl[4:2];
    {low_byte_wr_n_o, high_byte_wr_n_o} = ctl[1:0];
    word_addr_in_o = load ? a : ~word_addr_in_o; // released address wanders
    data_o = wr ? d : ~data_o; // released data wanders
    out_en_n_o = wr ? 1'b1 : oe_req;
    @(posedge clk_i);
    #1;
  endtask : cyc
  // output enable wanted on read cycles, applied at once
  task automatic set_oe(input logic v);
    oe_req = v;
    out_en_n_o = v;
  endtask : set_oe
endmodule : pbsram_host

/* File: verif/pbsram_top_bench.sv */
// self-checking bench for the pipelined burst memory
`timescale 1ns/1ps
module pbsram_top_bench;
  import pbsram_pkg::*;
  // cycle kinds {select, proc strobe, ctrl strobe, advance, low, high}
  localparam logic [5:0] PRD = 6'h0F, PWR = 6'h04, CRD = 6'h17, CWR = 6'h14, CWL = 6'h15, CWH = 6'h16;
  localparam logic [5:0] NXR = 6'h1B, NXW = 6'h18, HLD = 6'h1F, HLW = 6'h1C, DSP = 6'h2F, DSC = 6'h34;
  localparam int NONE = 0, RDV = 1, FLT = 2;
  logic              clk;
  logic              reset_n;
  logic              cs_n, ps_n, cc_n, adv_n, lw_n, hw_n, oe_n;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] host_data, pins_in, pins_out;
  logic              pins_oe_n;
  int                num_errors = 0;
  int                compares = 0;
  // clock and wire resolution
  initial clk = 1'b0;
  always #25 clk = ~clk;
  assign pins_in = pins_oe_n ? host_data : pins_out;
  pbsram_top i_pbsram_top (.clk_i(clk), .reset_n_i(reset_n), .ce_i(1'b1), .word_addr_in_i(addr),
    .proc_addr_strobe_n_i(ps_n), .ctrl_addr_strobe_n_i(cc_n), .burst_step_n_i(adv_n), .chip_sel_n_i(cs_n),
    .low_byte_wr_n_i(lw_n), .high_byte_wr_n_i(hw_n), .out_en_n_i(oe_n), .shared_data_pins_i(pins_in),
    .shared_data_pins_o(pins_out), .shared_data_pins_oe_n_o(pins_oe_n));
  pbsram_host i_pbsram_host (.clk_i(clk), .chip_sel_n_o(cs_n), .proc_addr_strobe_n_o(ps_n),
    .ctrl_addr_strobe_n_o(cc_n), .burst_step_n_o(adv_n), .low_byte_wr_n_o(lw_n), .high_byte_wr_n_o(hw_n),
    .out_en_n_o(oe_n), .word_addr_in_o(addr), .data_o(host_data));
  // compare and count
  task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    compares++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // one cycle, then judge the slot now on the pins
  task automatic step(input logic [5:0] c, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                      input int kind, input logic [DATA_W-1:0] exp);
    i_pbsram_host.cyc(c, a, d);
    if (kind == RDV)
    begin
      chk(pins_out, exp);
      chk({17'h00000, pins_oe_n}, {17'h00000, oe_n});
    end
    if (kind == FLT)
      chk({17'h00000, pins_oe_n}, 18'h00001);
  endtask : step
  // byte lanes, proc read ignoring enables, asynchronous output enable
  task automatic t_lanes();
    step(CWR, 16'h0100, 18'h2AAAA, NONE, 0);
    step(CWL, 16'h0100, 18'h15555, NONE, 0);
    step(PWR, 16'h0100, 18'h3FFFF, FLT, 0);
    step(CWH, 16'h0100, 18'h00000, RDV, (18'h2AAAA & 18'h3FE00) | (18'h15555 & 18'h001FF));
    step(CRD, 16'h0100, 0, FLT, 0);
    step(HLD, 16'h0100, 0, RDV, 18'h15555 & 18'h001FF);
    i_pbsram_host.set_oe(1'b1);
    #2;
    chk({17'h00000, pins_oe_n}, 18'h00001);
    @(posedge clk);
    #1;
    i_pbsram_host.set_oe(1'b0);
    #2;
    chk({17'h00000, pins_oe_n}, 18'h00000);
    @(posedge clk);
    #1;
  endtask : t_lanes
  // burst writes with a wait, wrap, burst reads with a wait
  task automatic t_burst();
    step(CWR, 16'h4A3D, 18'h3A001, NONE, 0);
    step(NXW, 16'h4A3D, 18'h3A002, NONE, 0);
    step(HLW, 16'h4A3D, 18'h3A003, NONE, 0);
    step(NXW, 16'h4A3D, 18'h3A004, NONE, 0);
    step(NXW, 16'h4A3D, 18'h3A005, NONE, 0);
    step(NXW, 16'h4A3D, 18'h3A006, NONE, 0);
    step(PRD, 16'h4A3D, 0, FLT, 0);
    step(NXR, 16'h4A3D, 0, RDV, 18'h3A006);
    step(HLD, 16'h4A3D, 0, RDV, 18'h3A003);
    step(NXR, 16'h4A3D, 0, RDV, 18'h3A003);
    step(NXR, 16'h4A3D, 0, RDV, 18'h3A004);
    step(NXR, 16'h4A3D, 0, RDV, 18'h3A005);
    step(CRD, 16'h4A3E, 0, RDV, 18'h3A006);
    step(HLD, 16'h4A3E, 0, RDV, 18'h3A005);
  endtask : t_burst
  // deselected cycles do nothing; proc-started write
  task automatic t_desel();
    step(CWR, 16'h0200, 18'h0ABCD, NONE, 0);
    step(DSC, 16'h0200, 18'h3FFFF, NONE, 0);
    step(HLW, 16'h0200, 18'h11111, NONE, 0);
    step(NXR, 16'h0200, 0, FLT, 0);
    step(DSP, 16'h0200, 0, FLT, 0);
    step(PRD, 16'h0200, 0, FLT, 0);
    step(HLW, 16'h0200, 18'h2468A, RDV, 18'h0ABCD);
    step(PRD, 16'h0200, 0, NONE, 0);
    step(HLD, 16'h0200, 0, RDV, 18'h2468A);
  endtask : t_desel
  // unbroken four-step read burst from an even base, then wrap
  task automatic t_wrap();
    step(PRD, 16'h4A3E, 0, RDV, 18'h2468A);
    step(NXR, 16'h4A3E, 0, RDV, 18'h3A005);
    step(NXR, 16'h4A3E, 0, RDV, 18'h3A004);
    step(NXR, 16'h4A3E, 0, RDV, 18'h3A003);
    step(NXR, 16'h4A3E, 0, RDV, 18'h3A006);
    step(HLD, 16'h4A3E, 0, RDV, 18'h3A005);
  endtask : t_wrap
  // verdict
  task automatic conclude();
    $display("compares=%0d num_errors=%0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : conclude
  // main sequence
  initial
  begin
    reset_n = 1'b0;
    repeat (20) @(posedge clk);
    #1;
    chk({17'h00000, pins_oe_n}, 18'h00001);
    reset_n = 1'b1;
    t_lanes();
    t_burst();
    t_desel();
    t_wrap();
    conclude();
  end
  // watchdog: about three and a half times the expected run
  initial
  begin
    #10000;
    num_errors++;
    conclude();
  end
endmodule : pbsram_top_bench
